// >>> rtl/dmacc_channel.sv
// one dma channel: control, status flags, transfer sequencer, data buffer
`include "dmacc_params.svh"

// How it works
// - with dummy write on, each destination write is followed by a source write
// - reload bit restores pointers and counter at the start of the next run
// - repeated modes always restore pointers and counter at count zero
// - request bit starts transfers and clears itself when they complete
// - source step mode: indirect or fixed keep, decrement, increment by size
// - destination step mode uses the same encoding on the destination
// - transfer mode: repeated continuous, continuous, repeated one-shot, one-shot
// - size bit one means bytes, zero means words; words after reset
// - channel on bit enables the channel, clearing it disables it
// - pending flag is one from buffer load until its final write
// - six-bit select picks one of 64 trigger inputs
// - upper flag set on access above the upper limit or ram top
// - lower flag set on access below lower limit but above special range
// - complete flag one after completion; cleared when a new session starts
// - halfway flag set when the counter reaches half its start value
// - retrigger flag set on a trigger while still busy
// - halfway enable adds a halfway interrupt to the completion interrupt
// - software writes to flags never raise an interrupt
// - limits are checked with the access itself, not ahead of it
// - each transfer reads into the buffer, then writes it out
// - address bit 0 picks byte lane; words step by two, bytes by one
// - counter steps down by one per transfer whatever the size
// - counter holds one after reset
// - a hardware trigger sets the request bit like software does
// - one-shot and continuous modes switch the channel off at count zero
module dmacc_channel #(
    parameter int          BUF_WIDTH = 17,
    parameter int          BUF_DEPTH = 2,
    parameter logic [15:0] RAM_TOP   = `DMACC_RAM_TOP
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    input  wire logic [2:0]                reg_sel,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    input  wire logic [15:0]               reg_wdata,
    output logic      [15:0]               reg_rdata,
    input  wire logic [15:0]               upper_limit_reg,
    input  wire logic [15:0]               lower_limit_reg,
    input  wire logic [63:0]               trig_in,
    output dmacc_pkg::dmacc_dbus_req_t     dbus_req,
    input  wire logic                      dbus_ack,
    input  wire logic [15:0]               dbus_rdata,
    output logic                           channel_irq
);
    import dmacc_pkg::*;

    localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

    dmacc_ctrl_t         ctrl;
    dmacc_stat_t         stat;
    dmacc_state_t        state;
    logic [15:0]         source_pointer;
    logic [15:0]         dest_pointer;
    logic [15:0]         transfer_counter;
    logic [15:0]         saved_src;
    logic [15:0]         saved_dst;
    logic [15:0]         saved_cnt;
    logic                reload_pending;
    logic                lim_abort;
    logic                trig_q;
    logic [BUF_WIDTH-1:0] data_holding_buffer [BUF_DEPTH];
    logic [PW-1:0]       wr_ptr;
    logic [PW-1:0]       rd_ptr;
    logic [PW:0]         fill;

    logic        wr_ctrl;
    logic        wr_stat;
    logic        wr_src;
    logic        wr_dst;
    logic        wr_cnt;
    logic        trig_now;
    logic        trig_edge;
    logic        busy;
    logic        restore_now;
    logic        issue;
    logic [15:0] issue_addr;
    logic [15:0] ea;
    logic        hi_hit;
    logic        lo_hit;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_ready;
    logic [BUF_WIDTH-1:0] fifo_head;
    logic [BUF_WIDTH-1:0] fifo_in_data;
    logic [15:0] cnt_dec;
    logic [15:0] half_mark;
    logic        done_ev;
    logic        half_ev;
    logic        repeated;
    logic        continuous;

    assign wr_ctrl = reg_wr && (reg_sel == `DMACC_IDX_CTRL);
    assign wr_stat = reg_wr && (reg_sel == `DMACC_IDX_STAT);
    assign wr_src  = reg_wr && (reg_sel == `DMACC_IDX_SRC);
    assign wr_dst  = reg_wr && (reg_sel == `DMACC_IDX_DST);
    assign wr_cnt  = reg_wr && (reg_sel == `DMACC_IDX_CNT);

    assign repeated   = ctrl.transfer_mode_sel[`DMACC_TM_REPEAT];
    assign continuous = ctrl.transfer_mode_sel[`DMACC_TM_CONT];

    // word mode forces bit 0 low, byte mode keeps it
    function automatic logic [15:0] eff_addr(input logic [15:0] a,
                                             input logic        byte_sz);
        eff_addr = byte_sz ? a : {a[15:1], 1'b0};
    endfunction

    function automatic logic [15:0] step_addr(input logic [15:0] a,
                                              input logic [1:0]  mode,
                                              input logic        byte_sz);
        logic [15:0] st;
        st = byte_sz ? `DMACC_STEP_BYTE : `DMACC_STEP_WORD;
        case (mode)
            `DMACC_AM_INC: step_addr = eff_addr(a, byte_sz) + st;
            `DMACC_AM_DEC: step_addr = eff_addr(a, byte_sz) - st;
            default:       step_addr = a; // fixed or peripheral indirect
        endcase
    endfunction

    function automatic logic [1:0] lane_of(input logic [15:0] a,
                                           input logic        byte_sz);
        if (!byte_sz) begin
            lane_of = `DMACC_LANE_WORD;
        end else begin
            lane_of = a[0] ? `DMACC_LANE_HI : `DMACC_LANE_LO;
        end
    endfunction

    // trigger selection and edge detect
    assign trig_now  = trig_in[stat.trigger_select];
    assign trig_edge = trig_now && !trig_q;
    assign busy      = (state != S_IDLE) || ctrl.soft_request;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trig_now;
        end
    end

    assign restore_now = (state == S_IDLE) && ctrl.channel_on &&
                         ctrl.soft_request && ctrl.reload &&
                         reload_pending;

    // next access address, checked as it goes out
    always_comb begin
        issue      = 1'b0;
        issue_addr = source_pointer;
        case (state)
            S_IDLE: begin
                issue = ctrl.channel_on && ctrl.soft_request &&
                        !restore_now && fifo_in_ready;
            end
            S_WRITE: begin
                issue      = !dbus_req.valid && fifo_out_valid;
                issue_addr = dest_pointer;
            end
            S_DUMMY: begin
                issue = !dbus_req.valid && fifo_out_valid;
            end
            default: begin
                issue = 1'b0;
            end
        endcase
    end

    assign ea     = eff_addr(issue_addr, ctrl.size_byte);
    assign hi_hit = issue && ((ea > upper_limit_reg) ||
                              (ea > RAM_TOP));
    assign lo_hit = issue && (ea < lower_limit_reg) &&
                    (ea > `DMACC_SFR_END);

    // two-entry data buffer between read and write phases
    assign fifo_in_valid  = (state == S_READ) && dbus_req.valid && dbus_ack;
    assign fifo_in_ready  = (fill != (PW+1)'(BUF_DEPTH));
    assign fifo_out_valid = (fill != '0);
    assign fifo_out_ready = dbus_req.valid && dbus_ack &&
                            (((state == S_WRITE) &&
                              !ctrl.dummy_write_enable) ||
                             (state == S_DUMMY));
    assign fifo_head      = data_holding_buffer[rd_ptr];
    assign fifo_in_data   = !ctrl.size_byte ? {1'b0, dbus_rdata} :
                            {1'b0, 8'h00, dbus_req.addr[0] ?
                             dbus_rdata[15:8] : dbus_rdata[7:0]};

    always_ff @(posedge ref_clk) begin
        if (fifo_in_valid && fifo_in_ready) begin
            data_holding_buffer[wr_ptr] <= fifo_in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (fifo_in_valid && fifo_in_ready) begin
                wr_ptr <= (wr_ptr == PW'(BUF_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (fifo_out_valid && fifo_out_ready) begin
                rd_ptr <= (rd_ptr == PW'(BUF_DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            fill <= fill + (PW+1)'(fifo_in_valid && fifo_in_ready)
                         - (PW+1)'(fifo_out_valid && fifo_out_ready);
        end
    end

    // transfer sequencer and data bus master
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state    <= S_IDLE;
            dbus_req <= '0;
        end else begin
            if (issue) begin
                dbus_req.valid <= 1'b1;
                dbus_req.write <= (state != S_IDLE);
                dbus_req.addr  <= ea;
                dbus_req.lanes <= lane_of(ea, ctrl.size_byte);
                dbus_req.wdata <= ctrl.size_byte ?
                                  {fifo_head[7:0], fifo_head[7:0]} :
                                  fifo_head[15:0];
            end else if (dbus_req.valid && dbus_ack) begin
                dbus_req.valid <= 1'b0;
            end
            case (state)
                S_IDLE: begin
                    if (issue) begin
                        state <= S_READ;
                    end
                end
                S_READ: begin
                    if (dbus_ack) begin
                        state <= S_WRITE;
                    end
                end
                S_WRITE: begin
                    if (dbus_req.valid && dbus_ack) begin
                        state <= ctrl.dummy_write_enable ? S_DUMMY
                                                         : S_CHECK;
                    end
                end
                S_DUMMY: begin
                    if (dbus_req.valid && dbus_ack) begin
                        state <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    assign cnt_dec   = transfer_counter - 16'h0001;
    assign half_mark = {1'b0, saved_cnt[15:1]};
    assign done_ev   = (state == S_CHECK) && (cnt_dec == 16'h0000);
    assign half_ev   = (state == S_CHECK) && (cnt_dec == half_mark) &&
                       (half_mark != 16'h0000);

    // pointers, counter and their saved copies
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            source_pointer   <= '0;
            dest_pointer     <= '0;
            transfer_counter <= `DMACC_CNT_RST;
            saved_src        <= '0;
            saved_dst        <= '0;
            saved_cnt        <= `DMACC_CNT_RST;
            reload_pending   <= 1'b0;
        end else begin
            if (state == S_CHECK) begin
                source_pointer   <= step_addr(source_pointer,
                                    ctrl.src_step_mode, ctrl.size_byte);
                dest_pointer     <= step_addr(dest_pointer,
                                    ctrl.dst_step_mode, ctrl.size_byte);
                transfer_counter <= cnt_dec;
                if (done_ev && repeated) begin
                    source_pointer   <= saved_src;
                    dest_pointer     <= saved_dst;
                    transfer_counter <= saved_cnt;
                end else if (done_ev) begin
                    reload_pending <= 1'b1;
                end
            end
            if (restore_now) begin
                source_pointer   <= saved_src;
                dest_pointer     <= saved_dst;
                transfer_counter <= saved_cnt;
                reload_pending   <= 1'b0;
            end
            if (wr_src) begin
                source_pointer <= reg_wdata;
                saved_src      <= reg_wdata;
            end
            if (wr_dst) begin
                dest_pointer <= reg_wdata;
                saved_dst    <= reg_wdata;
            end
            if (wr_cnt) begin
                transfer_counter <= reg_wdata;
                saved_cnt        <= reg_wdata;
                reload_pending   <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lim_abort <= 1'b0;
        end else if (hi_hit || lo_hit) begin
            lim_abort <= 1'b1;
        end else if (state == S_CHECK) begin
            lim_abort <= 1'b0;
        end
    end

    // control register: hardware clears, then software, then trigger set
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl <= `DMACC_CTRL_RST;
        end else begin
            if (state == S_CHECK) begin
                if (lim_abort) begin
                    ctrl.channel_on   <= 1'b0;
                    ctrl.soft_request <= 1'b0;
                end else if (done_ev) begin
                    ctrl.soft_request <= 1'b0;
                    if (!repeated) begin
                        ctrl.channel_on <= 1'b0;
                    end
                end else if (!continuous) begin
                    ctrl.soft_request <= 1'b0;
                end
            end
            if (wr_ctrl) begin
                ctrl <= reg_wdata & `DMACC_CTRL_WMASK;
            end
            if (trig_edge) begin
                ctrl.soft_request <= 1'b1;
            end
        end
    end

    // status flags: software writes first, hardware sets win
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stat <= `DMACC_STAT_RST;
        end else begin
            if (wr_stat) begin
                stat <= (reg_wdata & `DMACC_STAT_WMASK) |
                        {stat.buffer_pending_flag, 15'h0000};
            end
            if (wr_ctrl && reg_wdata[0] && !ctrl.channel_on) begin
                stat.complete_flag <= 1'b0;
            end
            if (fifo_in_valid && fifo_in_ready) begin
                stat.buffer_pending_flag <= 1'b1;
            end else if (fifo_out_valid && fifo_out_ready) begin
                stat.buffer_pending_flag <= 1'b0;
            end
            if (hi_hit) begin
                stat.upper_limit_flag <= 1'b1;
            end
            if (lo_hit) begin
                stat.lower_limit_flag <= 1'b1;
            end
            if (done_ev) begin
                stat.complete_flag <= 1'b1;
            end
            if (half_ev) begin
                stat.halfway_flag <= 1'b1;
            end
            if (trig_edge && busy) begin
                stat.retrigger_flag <= 1'b1;
            end
        end
    end

    // only hardware events reach the interrupt pulse
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            channel_irq <= 1'b0;
        end else begin
            channel_irq <= done_ev ||
                           (half_ev && stat.halfway_irq_enable);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_sel)
                `DMACC_IDX_CTRL: reg_rdata <= ctrl;
                `DMACC_IDX_STAT: reg_rdata <= stat;
                `DMACC_IDX_SRC:  reg_rdata <= source_pointer;
                `DMACC_IDX_DST:  reg_rdata <= dest_pointer;
                `DMACC_IDX_CNT:  reg_rdata <= transfer_counter;
                default:         reg_rdata <= 16'h0000;
            endcase
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_read_done;
        (state == S_READ) && dbus_ack;
    endsequence

    sequence s_dest_done;
        (state == S_WRITE) && dbus_req.valid && dbus_ack;
    endsequence

    property p_start_needs_on;
        (state == S_READ) && ($past(state) == S_IDLE) |-> $past(ctrl.channel_on);
    endproperty
    a_start_needs_on: assert property (p_start_needs_on)
        else $error("transfer started with channel off");

    property p_read_then_write;
        s_read_done |=> (state == S_WRITE) ##[1:2] dbus_req.write;
    endproperty
    a_read_then_write: assert property (p_read_then_write)
        else $error("read not followed by write");

    property p_dummy_follows;
        s_dest_done ##0 ctrl.dummy_write_enable |=> state == S_DUMMY;
    endproperty
    a_dummy_follows: assert property (p_dummy_follows)
        else $error("dummy write skipped");

    property p_pending_set;
        s_read_done |=> stat.buffer_pending_flag;
    endproperty
    a_pending_set: assert property (p_pending_set)
        else $error("pending flag not set after load");

    property p_count_step;
        (state == S_CHECK) && (transfer_counter > 16'h0001) && !reg_wr
        |=> transfer_counter == $past(transfer_counter) - 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step by one");

    property p_off_at_zero;
        (state == S_CHECK) && (transfer_counter == 16'h0001) && !repeated
        && !reg_wr |=> !ctrl.channel_on && stat.complete_flag;
    endproperty
    a_off_at_zero: assert property (p_off_at_zero)
        else $error("channel still on at count zero");

    property p_repeat_reload;
        (state == S_CHECK) && (transfer_counter == 16'h0001) && repeated
        && !reg_wr |=> transfer_counter == saved_cnt;
    endproperty
    a_repeat_reload: assert property (p_repeat_reload)
        else $error("repeated mode did not reload");

    property p_irq_from_hw;
        channel_irq |-> $past(state) == S_CHECK;
    endproperty
    a_irq_from_hw: assert property (p_irq_from_hw)
        else $error("interrupt without hardware event");

    property p_word_aligned;
        dbus_req.valid && !ctrl.size_byte && !$past(wr_ctrl)
        |-> !dbus_req.addr[0];
    endproperty
    a_word_aligned: assert property (p_word_aligned)
        else $error("word access on odd address");

    property p_retrigger;
        trig_edge && busy |=> stat.retrigger_flag;
    endproperty
    a_retrigger: assert property (p_retrigger)
        else $error("retrigger flag missed");

endmodule

// >>> rtl/dmacc_params.svh
// constants for the dma channel control and status block
`ifndef DMACC_PARAMS_SVH
`define DMACC_PARAMS_SVH

`define DMACC_IDX_CTRL   3'h0
`define DMACC_IDX_STAT   3'h1
`define DMACC_IDX_SRC    3'h2
`define DMACC_IDX_DST    3'h3
`define DMACC_IDX_CNT    3'h4

`define DMACC_CTRL_RST   16'h0000
`define DMACC_STAT_RST   16'h0000
`define DMACC_CNT_RST    16'h0001
`define DMACC_CTRL_WMASK 16'h07ff
`define DMACC_STAT_WMASK 16'h3ff9

`define DMACC_AM_INC     2'b01
`define DMACC_AM_DEC     2'b10
`define DMACC_TM_REPEAT  0
`define DMACC_TM_CONT    1

`define DMACC_STEP_BYTE  16'h0001
`define DMACC_STEP_WORD  16'h0002
`define DMACC_SFR_END    16'h07ff
`define DMACC_RAM_TOP    16'hffff
`define DMACC_LANE_WORD  2'b11
`define DMACC_LANE_LO    2'b01
`define DMACC_LANE_HI    2'b10

`endif

// >>> rtl/dmacc_pkg.sv
// types for the dma channel control and status block
package dmacc_pkg;

    typedef struct packed {
        logic [4:0] pad_hi;
        logic       dummy_write_enable;
        logic       reload;
        logic       soft_request;
        logic [1:0] src_step_mode;
        logic [1:0] dst_step_mode;
        logic [1:0] transfer_mode_sel;
        logic       size_byte;
        logic       channel_on;
    } dmacc_ctrl_t;

    typedef struct packed {
        logic       buffer_pending_flag;
        logic       pad_14;
        logic [5:0] trigger_select;
        logic       upper_limit_flag;
        logic       lower_limit_flag;
        logic       complete_flag;
        logic       halfway_flag;
        logic       retrigger_flag;
        logic [1:0] pad_lo;
        logic       halfway_irq_enable;
    } dmacc_stat_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [1:0]  lanes;
        logic [15:0] wdata;
    } dmacc_dbus_req_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_READ,
        S_WRITE,
        S_DUMMY,
        S_CHECK
    } dmacc_state_t;

endpackage

// >>> test/dmacc_bus_model.sv
// data bus partner: memory that acks promptly or slowly
module dmacc_bus_model (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  dmacc_pkg::dmacc_dbus_req_t dbus_req,
    input  wire logic                  slow,
    output logic                       dbus_ack,
    output logic [15:0]                dbus_rdata,
    output int                         n_rd,
    output int                         n_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    import dmacc_pkg::*;
    int w;
    // out of reset, data lines toggle whenever no answer is given, read or write
    always_ff @(posedge ref_clk) begin
        dbus_ack <= 1'b0;
        dbus_rdata <= ~dbus_rdata;
        if (rst) begin
            w <= 0;
            n_rd <= 0;
            n_wr <= 0;
            dbus_rdata <= 16'h0000;
        end else if (dbus_req.valid && !dbus_ack) begin
            w <= w + 1;
            if (w >= (slow ? 5 : 0)) begin
                w <= 0;
                dbus_ack <= 1'b1;
                dbus_rdata <= ~dbus_req.addr;
                n_rd <= n_rd + (dbus_req.write ? 0 : 1);
                n_wr <= n_wr + (dbus_req.write ? 1 : 0);
            end
        end
    end
endmodule

// >>> test/tb.sv
// self-checking bench for the dma channel block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dmacc_pkg::*;
    logic            ref_clk = 1'b0;
    logic            rst = 1'b1;
    logic [2:0]      reg_sel = 3'h0;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    logic [15:0]     reg_wdata = 16'h0000;
    logic [15:0]     reg_rdata;
    logic [63:0]     trig_in = 64'h0;
    logic            slow = 1'b0;
    dmacc_dbus_req_t dbus_req;
    logic            dbus_ack;
    logic            channel_irq;
    logic [15:0]     dbus_rdata;
    int              n_rd, n_wr, n_irq = 0, cyc = 0;
    int              fail_count = 0, n_checks = 0;
    logic            mode_b = 1'b0;
    logic [15:0]     last_rd = 16'h0000;
    logic [15:0]     lane_x;
    logic [7:0]      rd_byte;
    always #5 ref_clk = ~ref_clk;
    dmacc_channel i_dmacc_channel (.ref_clk(ref_clk), .rst(rst),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .upper_limit_reg(16'hffff), .lower_limit_reg(16'h0000),
        .trig_in(trig_in), .dbus_req(dbus_req), .dbus_ack(dbus_ack),
        .dbus_rdata(dbus_rdata), .channel_irq(channel_irq));
    dmacc_bus_model i_dmacc_bus_model (.ref_clk(ref_clk), .rst(rst),
        .dbus_req(dbus_req), .slow(slow), .dbus_ack(dbus_ack),
        .dbus_rdata(dbus_rdata), .n_rd(n_rd), .n_wr(n_wr));
    task automatic tally_and_finish;
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (channel_irq === 1'b1) n_irq++;
        if (cyc == 6000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // lanes of every access, and write data against the word last read
    always @(posedge ref_clk) begin
        if (dbus_req.valid && dbus_ack) begin
            lane_x = !mode_b ? 16'h0003 : 16'h0001 << dbus_req.addr[0];
            check(16'(dbus_req.lanes), lane_x);
            if (!dbus_req.write) begin
                last_rd = dbus_req.addr;
            end else begin
                rd_byte = last_rd[0] ? ~last_rd[15:8] : ~last_rd[7:0];
                lane_x = mode_b ? {2{rd_byte}} : ~last_rd;
                check(dbus_req.wdata, lane_x);
            end
        end
    end
    task automatic wr(input logic [2:0] s, input logic [15:0] d);
        @(negedge ref_clk);
        reg_sel = s;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    task automatic chk(input logic [2:0] s, input logic [15:0] e);
        @(negedge ref_clk);
        reg_sel = s;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        @(negedge ref_clk);
        check(reg_rdata, e);
    endtask
    task automatic wait_irq(input int target);
        for (int t = 0; t < 500 && n_irq < target; t++) @(negedge ref_clk);
        repeat (4) @(negedge ref_clk);
    endtask
    // expected pointer after n steps in the given step mode
    function automatic logic [15:0] ep(logic [15:0] a, logic [1:0] m,
                                      logic b, int n);
        logic [15:0] st;
        st = 16'(n) << (b ? 0 : 1);
        if (m == 2'b01) return a + st;
        if (m == 2'b10) return a - st;
        return a;
    endfunction
    initial begin
        logic [15:0] s, d, c;
        logic [1:0]  sm, dm;
        logic        b, nw, he;
        logic [5:0]  ts;
        int          n, r0, w0, i0;
        void'($urandom(10096));
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        chk(0, 16'h0000);
        chk(4, 16'h0001);
        wr(5, 16'hffff);
        chk(5, 16'h0000);
        wr(1, 16'hfff8);
        chk(1, 16'h3ff8);
        check(16'(n_irq), 16'h0000);
        wr(1, 16'h0000);
        for (int k = 0; k < 12; k++) begin
            b = (k < 4) ? 1'b0 : 1'($urandom);
            mode_b = b;
            sm = (k < 4) ? 2'(k) : 2'($urandom);
            dm = (k < 4) ? 2'(3 - k) : 2'($urandom);
            nw = 1'($urandom);
            he = 1'($urandom);
            n = 1 + $urandom % 4;
            s = {4'h2, 11'($urandom), b & 1'($urandom)};
            d = {4'h4, 11'($urandom), b & 1'($urandom)};
            c = {5'h0, nw, 2'b01, sm, dm, 2'b10, b, 1'b1};
            wr(2, s);
            wr(3, d);
            wr(4, 16'(n));
            wr(1, {15'h0, he});
            r0 = n_rd;
            w0 = n_wr;
            i0 = n_irq;
            wr(0, c);
            wait_irq(i0 + 1 + int'(he && n > 1));
            check(16'(n_rd - r0), 16'(n));
            check(16'(n_wr - w0), 16'(n * (1 + nw)));
            chk(2, ep(s, sm, b, n));
            chk(3, ep(d, dm, b, n));
            chk(4, 16'h0000);
            chk(0, c & 16'hfefe);
            chk(1, {10'h0, 1'b1, n > 1, 3'h0, he});
            check(16'(n_irq - i0), 16'(1 + int'(he && n > 1)));
        end
        mode_b = 1'b0;
        wr(1, 16'h0000);
        wr(2, 16'h2100);
        wr(4, 16'h0002);
        i0 = n_irq;
        wr(0, 16'h015d);
        wait_irq(i0 + 1);
        chk(2, 16'h2100);
        chk(4, 16'h0002);
        chk(0, 16'h005d);
        wr(2, 16'h2200);
        wr(4, 16'h0001);
        i0 = n_irq;
        wr(0, 16'h0151);
        wait_irq(i0 + 1);
        i0 = n_irq;
        wr(0, 16'h0351);
        wait_irq(i0 + 1);
        chk(2, 16'h2202);
        chk(4, 16'h0000);
        slow = 1'b1;
        ts = 6'($urandom);
        wr(1, {2'b00, ts, 8'h00});
        wr(4, 16'h0001);
        wr(0, 16'h0001);
        r0 = n_rd;
        i0 = n_irq;
        trig_in = ~(64'h1 << ts);
        repeat (4) @(negedge ref_clk);
        check(16'(n_rd - r0), 16'h0000);
        trig_in = '1;
        repeat (4) @(negedge ref_clk);
        trig_in = ~(64'h1 << ts);
        @(negedge ref_clk);
        trig_in = '1;
        wait_irq(i0 + 1);
        trig_in = 64'h0;
        chk(1, {2'b00, ts, 8'h28});
        tally_and_finish;
    end
endmodule
